/* File: design/asc_pkg.sv */
// Purpose: Shared constants and carriers for the static memory controller
// Assumes: 100 MHz clock, 10 ns period
// Notes:   Times in ps, cycle counts derived from them
package asc_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int DEPTH  = 131072;
    localparam int CLK_PS = 10000;

    localparam int READ_PERIOD_MIN_PS          = 10000;
    localparam int ADDR_TO_DATA_DELAY_PS       = 10000;
    localparam int UNDRIVE_TO_FLOAT_DELAY_PS   = 5000;
    localparam int DESELECT_TO_FLOAT_DELAY_PS  = 5000;
    localparam int STROBE_TO_FLOAT_DELAY_PS    = 5000;
    localparam int WRITE_PERIOD_MIN_PS         = 10000;
    localparam int SELECT_BEFORE_WRITE_END_PS  = 7000;
    localparam int ADDR_BEFORE_WRITE_END_PS    = 7000;
    localparam int DATA_BEFORE_WRITE_END_PS    = 5000;
    localparam int WRITE_PULSE_MIN_PS          = 7000;

    function automatic int min_cycles(input int ps);
        int c;
        c = (ps + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int READ_CYC  = min_cycles(ADDR_TO_DATA_DELAY_PS + 0) + 1;
    localparam int FLOAT_CYC = min_cycles(UNDRIVE_TO_FLOAT_DELAY_PS);
    localparam int WP_CYC    = min_cycles(WRITE_PULSE_MIN_PS);
    localparam int WR_CYC    = (WP_CYC > min_cycles(WRITE_PERIOD_MIN_PS)) ? WP_CYC
                             : min_cycles(WRITE_PERIOD_MIN_PS);
    localparam int CNT_W     = 4;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asc_req_t;

    typedef struct packed {
        logic              ce_n;
        logic              we_n;
        logic              oe_n;
        logic [ADDR_W-1:0] addr;
    } asc_pins_t;
endpackage

/* File: design/asc_ctrl.sv */
// Purpose: Controller driving an asynchronous 128K x 8 static memory
// Assumes: Memory pins wired directly; data pin split into in/out/enable
// Notes:   One request at a time; REQ_READY high only in idle
`timescale 1ns/10ps
module asc_ctrl
    import asc_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              REQ_VALID,
    output logic                   REQ_READY,
    input  wire asc_req_t          REQ,
    output logic                   RD_VALID,
    output logic [DATA_W-1:0]      RD_DATA,
    output asc_pins_t              MEM,
    input  wire logic [DATA_W-1:0] MEM_DQ_IN,
    output logic [DATA_W-1:0]      MEM_DQ_OUT,
    output logic                   MEM_DQ_OE
);
    // Sequencer states, one access at a time
    typedef enum logic [2:0] {
        S_IDLE,
        S_RSET,
        S_READ,
        S_RFLT,
        S_WSET,
        S_WSTB,
        S_WEND
    } asc_st_t;

    asc_st_t           st_q, st_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    asc_pins_t         pin_q, pin_d;
    logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
    logic              oe_q, oe_d, rv_q, rv_d;
    logic [DATA_W-1:0] dq_s1_q, dq_s2_q;

    // Pin input synchroniser
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            dq_s1_q <= 8'h00;
            dq_s2_q <= 8'h00;
        end else begin
            dq_s1_q <= MEM_DQ_IN;
            dq_s2_q <= dq_s1_q;
        end
    end

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        pin_d = pin_q;
        wd_d  = wd_q;
        rd_d  = rd_q;
        oe_d  = oe_q;
        rv_d  = 1'b0;
        unique case (st_q)
            S_IDLE: begin
                pin_d.ce_n = 1'b1;
                pin_d.we_n = 1'b1;
                pin_d.oe_n = 1'b1;
                oe_d       = 1'b0;
                if (REQ_VALID) begin
                    pin_d.addr = REQ.addr;
                    wd_d       = REQ.wdata;
                    cnt_d      = '0;
                    st_d       = REQ.write ? S_WSET : S_RSET;
                end
            end
            S_RSET: begin
                // Address settled one cycle before select falls
                pin_d.ce_n = 1'b0;
                pin_d.oe_n = 1'b0;
                pin_d.we_n = 1'b1;
                st_d       = S_READ;
            end
            S_READ: begin
                // Wait access time plus two sync stages
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(READ_CYC + 1)) begin
                    rd_d       = dq_s2_q;
                    rv_d       = 1'b1;
                    pin_d.ce_n = 1'b1;
                    pin_d.oe_n = 1'b1;
                    cnt_d      = '0;
                    st_d       = S_RFLT;
                end
            end
            S_RFLT: begin
                // Let the memory float before next access
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(FLOAT_CYC - 1)) begin
                    st_d = S_IDLE;
                end
            end
            S_WSET: begin
                pin_d.ce_n = 1'b0;
                pin_d.we_n = 1'b0;
                pin_d.oe_n = 1'b1;
                cnt_d      = '0;
                st_d       = S_WSTB;
            end
            S_WSTB: begin
                // Drive data only after strobe has floated the memory
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(min_cycles(STROBE_TO_FLOAT_DELAY_PS) - 1)) begin
                    oe_d = 1'b1;
                end
                if (cnt_q == CNT_W'(WR_CYC + min_cycles(DATA_BEFORE_WRITE_END_PS) - 1)) begin
                    // Strobe rises first, ending the write
                    pin_d.we_n = 1'b1;
                    st_d       = S_WEND;
                end
            end
            S_WEND: begin
                // Hold address and data one cycle past the end
                pin_d.ce_n = 1'b1;
                oe_d       = 1'b0;
                st_d       = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q  <= S_IDLE;
            cnt_q <= '0;
            pin_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 17'h00000};
            wd_q  <= 8'h00;
            rd_q  <= 8'h00;
            oe_q  <= 1'b0;
            rv_q  <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            pin_q <= pin_d;
            wd_q  <= wd_d;
            rd_q  <= rd_d;
            oe_q  <= oe_d;
            rv_q  <= rv_d;
        end
    end

    assign REQ_READY  = (st_q == S_IDLE);
    assign RD_VALID   = rv_q;
    assign RD_DATA    = rd_q;
    assign MEM        = pin_q;
    assign MEM_DQ_OUT = wd_q;
    assign MEM_DQ_OE  = oe_q;
endmodule

/* File: tb/asc_mem_model.sv */
// Purpose: Memory model
// Assumes: Pins from asc_ctrl
// Notes:   Freed bus shows inverted last value
`timescale 1ns/10ps
module asc_mem_model
    import asc_pkg::*;
(
    input  asc_pins_t         pins,
    input  logic              c_oe,
    input  logic [DATA_W-1:0] c_dq,
    output logic [DATA_W-1:0] dq
);
    logic [DATA_W-1:0] arr [DEPTH];
    logic [DATA_W-1:0] last;
    wire  [DATA_W-1:0] rd;
    wire               mo;
    assign #5 mo = !pins.ce_n && !pins.oe_n
                   && pins.we_n;
    assign #5 rd = arr[pins.addr];
    assign dq = (c_oe && mo) ? 'x : c_oe ? c_dq : mo ? rd : ~last;
    always @(dq) if (c_oe || mo) last = dq;
    always @(posedge pins.we_n) if (!pins.ce_n) arr[pins.addr] = c_dq;
    always @(posedge pins.ce_n) if (!pins.we_n) arr[pins.addr] = c_dq;
endmodule

/* File: tb/asc_ctrl_chk.sv */
// Purpose: Pin checks
// Assumes: Bound to asc_ctrl
// Notes:   Rising CLK sampling
`timescale 1ns/10ps
module asc_ctrl_chk
    import asc_pkg::*;
(
    input logic              CLK,
    input logic              RST_N,
    input logic              RD_VALID,
    input asc_pins_t         MEM,
    input logic [DATA_W-1:0] MEM_DQ_OUT,
    input logic              MEM_DQ_OE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    we_rd_a: assert property (!MEM.oe_n |-> MEM.we_n) else $error("strobe");
    oe_off_a: assert property (MEM_DQ_OE |-> MEM.oe_n) else $error("clash");
    addr_hold_a: assert property (!MEM.ce_n && !$past(MEM.ce_n)
        |-> $stable(MEM.addr)) else $error("addr");
    addr_pre_a: assert property ($fell(MEM.ce_n) |-> $stable(MEM.addr))
        else $error("setup");
    sel_end_a: assert property ($rose(MEM.we_n)
        |-> !$past(MEM.ce_n) && !MEM.ce_n) else $error("select");
    data_end_a: assert property ($rose(MEM.we_n)
        |-> $past(MEM_DQ_OE) && $stable(MEM_DQ_OUT)) else $error("data");
    we_wide_a: assert property ($fell(MEM.we_n)
        |-> !MEM.ce_n ##1 !MEM.we_n) else $error("pulse");
    rd_span_a: assert property (RD_VALID
        |-> !$past(MEM.oe_n, 3) && !$past(MEM.oe_n)) else $error("span");
    cover property (RD_VALID);
    cover property ($rose(MEM.we_n));
    cover property ($fell(MEM_DQ_OE));
endmodule
bind asc_ctrl asc_ctrl_chk i_chk (.CLK(CLK), .RST_N(RST_N), .RD_VALID(RD_VALID),
    .MEM(MEM), .MEM_DQ_OUT(MEM_DQ_OUT), .MEM_DQ_OE(MEM_DQ_OE));

/* File: tb/asc_ctrl_tb_top.sv */
// Purpose: Bench for asc_ctrl
// Assumes: Memory model at the pins
// Notes:   Inputs change on falling edge
`timescale 1ns/10ps
module asc_ctrl_tb_top
    import asc_pkg::*;
;
    logic              clk = 0, rst_n = 0, vld = 0, rdy, oe, rv;
    asc_req_t          req = '0;
    asc_pins_t         pins;
    logic [DATA_W-1:0] rd, din, dout;
    int                failures = 0, comparisons = 0;
    always #5 clk = ~clk;
    asc_ctrl i_dut (.CLK(clk), .RST_N(rst_n), .REQ_VALID(vld), .REQ_READY(rdy),
        .REQ(req), .RD_VALID(rv), .RD_DATA(rd), .MEM(pins), .MEM_DQ_IN(din),
        .MEM_DQ_OUT(dout), .MEM_DQ_OE(oe));
    asc_mem_model i_mem (.pins(pins), .c_oe(oe), .c_dq(dout), .dq(din));
    task automatic chk(string s, logic [DATA_W-1:0] v, e);
        comparisons++;
        if (v !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", s, e, v);
        end
    endtask
    task automatic close_out;
        $display("%0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output logic seen);
        seen = 1'b0;
        vld  = 1'b1;
        req  = '{w, a, d};
        @(negedge clk);
        vld = 1'b0;
        for (int n = 0; n < 20 && rdy !== 1'b1; n++) begin
            seen = seen | (rv === 1'b1);
            @(negedge clk);
        end
        if (rdy !== 1'b1) failures++;
    endtask
    task automatic t_rw;
        logic [ADDR_W-1:0] a [4] = '{17'h00000, 17'h1ffff, 17'h0aaaa, 17'h00000};
        logic [DATA_W-1:0] d [4] = '{8'ha5, 8'h5a, 8'hff, 8'hc3};
        logic              s;
        foreach (a[i]) begin
            acc(1'b1, a[i], d[i], s);
            chk("stored", i_mem.arr[a[i]], d[i]);
            chk("wr rd_valid", {7'h00, s}, 8'h00);
        end
        for (int i = 1; i < 4; i++) begin
            acc(1'b0, a[i], 8'h00, s);
            chk("read", rd, d[i]);
            chk("rd_valid", {7'h00, s}, 8'h01);
        end
        $display("rw test done");
    endtask
    task automatic t_rst;
        logic s;
        acc(1'b1, 17'h00123, 8'h3c, s);
        rst_n = 1'b0;
        @(negedge clk);
        chk("ce_n", {7'h00, pins.ce_n}, 8'h01);
        chk("ready", {7'h00, rdy}, 8'h01);
        chk("dq_oe", {7'h00, oe}, 8'h00);
        rst_n = 1'b1;
        acc(1'b0, 17'h00123, 8'h00, s);
        chk("rst read", rd, 8'h3c);
        chk("rst rd_valid", {7'h00, s}, 8'h01);
        $display("reset test done");
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        t_rw();
        t_rst();
        close_out();
    end
    initial begin
        #20000;
        failures++;
        close_out();
    end
endmodule
